// ---- verilog/lpbc_params.svh ----
// Register map, field positions, reset values and cycle counts of the executer
`ifndef LPBC_PARAMS_SVH
`define LPBC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LPBC_OFS_CTRL 6'h00
`define LPBC_OFS_INSN 6'h04
`define LPBC_OFS_OPA 6'h08
`define LPBC_OFS_OPB 6'h0c
`define LPBC_OFS_BND 6'h10
`define LPBC_OFS_MOFS 6'h14
`define LPBC_OFS_RESULT 6'h18
`define LPBC_OFS_STATUS 6'h1c
`define LPBC_OFS_CYCLES 6'h20
`define LPBC_OFS_IRQ_STAT 6'h24
`define LPBC_OFS_IRQ_MASK 6'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LPBC_CTRL_GO 0
`define LPBC_CTRL_PROT 1
`define LPBC_CTRL_WRITABLE 2
`define LPBC_CTRL_ADDR_BAD 3
`define LPBC_CTRL_STACK_SEG 4
`define LPBC_CTRL_KIND_LSB 5
`define LPBC_CTRL_TASK_GATE 7
`define LPBC_CTRL_NEXT_LSB 8
`define LPBC_CTRL_RST 16'h0000
`define LPBC_MASK_RST 2'b00
`define LPBC_FLAGS_RST 6'h00

// ----------------------------------------------------------------
// Opcodes and format-byte register fields
// ----------------------------------------------------------------
`define LPBC_OP_AND_LO 8'h20
`define LPBC_OP_AND_HI 8'h23
`define LPBC_OP_AND_ACC_B 8'h24
`define LPBC_OP_AND_ACC_W 8'h25
`define LPBC_OP_GRP_B 8'h80
`define LPBC_OP_GRP_W 8'h81
`define LPBC_OP_ADJ 8'h63
`define LPBC_OP_BOUND 8'h62
`define LPBC_OP_CALL_REL 8'he8
`define LPBC_OP_GRP_FF 8'hff
`define LPBC_OP_CALL_FAR 8'h9a
`define LPBC_SUB_AND 3'h4
`define LPBC_SUB_CALL_NEAR 3'h2
`define LPBC_SUB_CALL_FAR 3'h3

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define LPBC_CYC_AND_REG 16'h0002
`define LPBC_CYC_AND_IMM 16'h0003
`define LPBC_CYC_MEM 16'h0007
`define LPBC_CYC_ADJ_REG 16'h000a
`define LPBC_CYC_ADJ_MEM 16'h000b
`define LPBC_CYC_BOUND 16'h000d
`define LPBC_CYC_NEAR 16'h0007
`define LPBC_CYC_NEAR_MEM 16'h000b
`define LPBC_CYC_FAR_REAL 16'h000d
`define LPBC_CYC_FAR_PM 16'h001a
`define LPBC_CYC_GATE_SAME 16'h0029
`define LPBC_CYC_GATE_MORE 16'h0052
`define LPBC_CYC_GATE_PARM 16'h0056
`define LPBC_CYC_TASK_SEG 16'h00b1
`define LPBC_CYC_TASK_GATE 16'h00b6
`define LPBC_CYC_IFAR_REAL 16'h0010
`define LPBC_CYC_IFAR_PM 16'h001d
`define LPBC_CYC_IGATE_SAME 16'h002c
`define LPBC_CYC_IGATE_MORE 16'h0053
`define LPBC_CYC_IGATE_PARM 16'h005a
`define LPBC_CYC_ITASK_SEG 16'h00b4
`define LPBC_CYC_ITASK_GATE 16'h00b9
`define LPBC_CYC_FAULT 16'h0001

// ----------------------------------------------------------------
// Vectors and limits
// ----------------------------------------------------------------
`define LPBC_VEC_BOUND 8'h05
`define LPBC_VEC_UD 8'h06
`define LPBC_VEC_SS 8'h0c
`define LPBC_VEC_GP 8'h0d
`define LPBC_BOUND_OFS_LIMIT 16'hfffd
`define LPBC_PARM_MASK 5'h1f

`endif

// ---- verilog/lpbc_pkg.sv ----
// Types shared by the instruction executer
package lpbc_pkg;

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
typedef enum logic {
    LPBC_IDLE = 1'b0,
    LPBC_RUN = 1'b1
} lpbc_state_e;

// ----------------------------------------------------------------
// Far-call target kinds
// ----------------------------------------------------------------
typedef enum logic [1:0] {
    LPBC_FAR_CODE = 2'b00,
    LPBC_FAR_GATE_SAME = 2'b01,
    LPBC_FAR_GATE_MORE = 2'b10,
    LPBC_FAR_TASK = 2'b11
} lpbc_far_kind_e;

// Flags in order {overflow, sign, zero, aux, parity, carry}
typedef logic [5:0] lpbc_flags_t;

endpackage : lpbc_pkg

// ---- verilog/lpbc_cycle_timer.sv ----
// Down-counter that holds the executer busy for a given number of cycles
`timescale 1ns/1ps
module lpbc_cycle_timer #(
    parameter int CYC_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [CYC_W-1:0] count,
    output logic busy,
    output logic done
);

    // Remaining cycles of the instruction in flight
    logic [CYC_W-1:0] remain;

    // ----------------------------------------------------------------
    // Count down, pulse done on the last cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remain <= '0;
            done <= 1'b0;
        end else if (ce) begin
            // A load wins over the countdown
            if (load) begin
                remain <= count;
            end else if (remain != '0) begin
                remain <= remain - 1'b1;
            end
            done <= !load && (remain == {{(CYC_W-1){1'b0}}, 1'b1});
        end
    end

    assign busy = (remain != '0);

endmodule : lpbc_cycle_timer

// ---- verilog/lpbc_exec.sv ----
// Executer for the logical-and, privilege-adjust, bounds-check and call instructions
// Operation
// - Decode and opcodes 20-25, 80/4, 81/4
// - And result bitwise, replaces first operand
// - And clears overflow/carry, sets sign/zero/parity
// - And cycles 2 reg, 3 immediate, 7 memory
// - Protected non-writable destination raises protection fault
// - Illegal address in protected mode: protection fault, stack fault
// - Adjust opcode 63, 10 or 11 cycles
// - Adjust raises lower privilege field, sets zero
// - Adjust in real mode raises interrupt 6
// - Bounds check raises interrupt 5 outside range
// - Bounds register operand gives invalid-opcode fault
// - Real-mode bounds offset from FFFD raises 13
// - Near calls E8 and FF/2 with cycles
// - Immediate far call cycle costs per target
// - Indirect far call cycle costs per target
// - Call cycles add next instruction byte count
// - Relative call adds displacement, pushes next offset
// - Gate parameter count masked to five bits
`timescale 1ns/1ps
`include "lpbc_params.svh"
module lpbc_exec #(
    parameter int CYC_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    // The largest count (90 + 4*31 + 15) fits in eight bits
    generate
        if (CYC_W < 9 || CYC_W > 16) begin : g_bad_width
            $error("lpbc_exec: CYC_W must lie between 9 and 16");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Apply Avalon byte enables to a register word
    function automatic logic [31:0] lpbc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : lpbc_merge

    // A format byte names a memory operand unless its mode field is 3
    function automatic logic lpbc_is_mem(input logic [7:0] fmt);
        return fmt[7:6] != 2'b11;
    endfunction : lpbc_is_mem

    // ----------------------------------------------------------------
    // Software-visible state
    // ----------------------------------------------------------------
    logic [15:0] ctrl; // Mode and qualifier bits
    logic [15:0] insn; // {format byte, opcode}
    logic [15:0] opa; // First operand, or offset of next instruction
    logic [15:0] opb; // Second operand, immediate or displacement
    logic [31:0] bnd; // {upper bound, lower bound}
    logic [20:0] mofs; // {gate word count, memory operand offset}
    logic [31:0] result; // {pushed word, result or new offset}
    lpbc_pkg::lpbc_flags_t flags; // Arithmetic flags kept by the executer
    logic [7:0] fault_vec; // Fault vector of the last instruction, zero if it did not fault
    logic fault_hit; // Last instruction faulted
    logic [4:0] parm_cnt; // Words copied to the new stack
    logic [15:0] cycles; // Cycle cost of the last instruction
    logic [1:0] irq_stat; // {fault, done} sticky events
    logic [1:0] irq_mask; // Enables for irq_stat
    lpbc_pkg::lpbc_state_e state; // Sequencer state

    // ----------------------------------------------------------------
    // Avalon slave handshake
    // ----------------------------------------------------------------
    // One wait cycle per access; the write lands when waitrequest is low
    wire bus_req = avs_read || avs_write;
    wire bus_fire = bus_req && !avs_waitrequest;
    wire wr_fire = avs_write && !avs_waitrequest;
    wire hit_ctrl = (avs_address == `LPBC_OFS_CTRL);
    wire hit_insn = (avs_address == `LPBC_OFS_INSN);
    wire hit_opa = (avs_address == `LPBC_OFS_OPA);
    wire hit_opb = (avs_address == `LPBC_OFS_OPB);
    wire hit_bnd = (avs_address == `LPBC_OFS_BND);
    wire hit_mofs = (avs_address == `LPBC_OFS_MOFS);
    wire hit_stat = (avs_address == `LPBC_OFS_IRQ_STAT);
    wire hit_mask = (avs_address == `LPBC_OFS_IRQ_MASK);
    wire idle = (state == lpbc_pkg::LPBC_IDLE);
    // Operand registers are frozen while an instruction runs
    wire wr_ops = wr_fire && idle;
    wire go = wr_ops && hit_ctrl && avs_byteenable[0] && avs_writedata[`LPBC_CTRL_GO];

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire [7:0] op = insn[7:0];
    wire [7:0] fmt = insn[15:8];
    wire [2:0] sub = fmt[5:3];
    wire mem = lpbc_is_mem(fmt);
    wire prot = ctrl[`LPBC_CTRL_PROT];
    wire [15:0] next_len = {12'h000, ctrl[`LPBC_CTRL_NEXT_LSB +: 4]};
    wire [1:0] kind = ctrl[`LPBC_CTRL_KIND_LSB +: 2];
    wire [4:0] wc = mofs[20:16] & `LPBC_PARM_MASK;
    // Conjunction forms
    wire and_rm = (op >= `LPBC_OP_AND_LO) && (op <= `LPBC_OP_AND_HI);
    wire and_acc = (op == `LPBC_OP_AND_ACC_B) || (op == `LPBC_OP_AND_ACC_W);
    wire grp_imm = (op == `LPBC_OP_GRP_B) || (op == `LPBC_OP_GRP_W);
    wire and_imm = grp_imm && (sub == `LPBC_SUB_AND);
    wire and_any = and_rm || and_acc || and_imm;
    wire and_word = op[0];
    // Memory destination only for the forms whose result goes to the operand
    wire and_dst_mem = mem && (and_imm || op == `LPBC_OP_AND_LO || op == 8'h21);
    // Other instructions
    wire adj = (op == `LPBC_OP_ADJ);
    wire bound = (op == `LPBC_OP_BOUND);
    wire is_ff = (op == `LPBC_OP_GRP_FF);
    wire call_rel = (op == `LPBC_OP_CALL_REL);
    wire call_ind = is_ff && (sub == `LPBC_SUB_CALL_NEAR);
    wire call_far = (op == `LPBC_OP_CALL_FAR);
    wire call_fmem = is_ff && (sub == `LPBC_SUB_CALL_FAR);
    wire is_call = call_rel || call_ind || call_far || call_fmem;
    wire known = and_any || adj || bound || is_call;
    // Memory operand touched by the instruction
    wire mem_use = bound || (mem && (and_rm || and_imm || adj || call_ind || call_fmem));

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    wire [15:0] and_full = opa & opb;
    // Byte forms keep the upper half of the first operand
    wire [15:0] and_res = and_word ? and_full : {opa[15:8], and_full[7:0]};
    wire and_sign = and_word ? and_res[15] : and_res[7];
    wire and_zero = and_word ? (and_res == 16'h0000) : (and_res[7:0] == 8'h00);
    wire and_par = ~^and_res[7:0];
    // Privilege field of the selector sits in the two low bits
    wire adj_raise = opa[1:0] < opb[1:0];
    wire [15:0] adj_res = adj_raise ? {opa[15:2], opb[1:0]} : opa;
    // Signed index against the two memory words
    wire bnd_out = ($signed(opa) < $signed(bnd[15:0])) ||
                   ($signed(opa) > $signed(bnd[31:16]));
    // Displacement wraps modulo 65536 onto the next offset
    wire [15:0] rel_target = opa + opb;
    wire [15:0] call_target = call_rel ? rel_target : opb;

    // ----------------------------------------------------------------
    // Fault detection, highest priority first
    // ----------------------------------------------------------------
    wire f_ud = !known || (adj && !prot) || (bound && !lpbc_is_mem(fmt));
    wire f_addr = prot && mem_use && ctrl[`LPBC_CTRL_ADDR_BAD];
    wire f_rofs = bound && !prot && (mofs[15:0] >= `LPBC_BOUND_OFS_LIMIT);
    wire f_wp = prot && (and_dst_mem || (adj && mem)) &&
                !ctrl[`LPBC_CTRL_WRITABLE];
    wire f_bnd = bound && bnd_out;
    wire f_any = f_ud || f_addr || f_rofs || f_wp || f_bnd;
    // Stack-segment operands take the stack fault instead
    wire [7:0] addr_vec = ctrl[`LPBC_CTRL_STACK_SEG] ? `LPBC_VEC_SS : `LPBC_VEC_GP;
    wire [7:0] vec_sel = f_ud ? `LPBC_VEC_UD :
                         f_addr ? addr_vec :
                         (f_rofs || f_wp) ? `LPBC_VEC_GP :
                         f_bnd ? `LPBC_VEC_BOUND : 8'h00;

    // ----------------------------------------------------------------
    // Cycle cost
    // ----------------------------------------------------------------
    wire [15:0] parm4 = {9'h000, wc, 2'b00};
    wire [15:0] cyc_and = (and_rm && !mem) ? `LPBC_CYC_AND_REG :
                          (and_acc || !mem) ? `LPBC_CYC_AND_IMM : `LPBC_CYC_MEM;
    wire [15:0] cyc_adj = mem ? `LPBC_CYC_ADJ_MEM : `LPBC_CYC_ADJ_REG;
    wire [15:0] cyc_near = (call_ind && mem) ? `LPBC_CYC_NEAR_MEM : `LPBC_CYC_NEAR;
    // Immediate pointer far call
    wire [15:0] cyc_fi_more = (wc == 5'h00) ? `LPBC_CYC_GATE_MORE :
                              `LPBC_CYC_GATE_PARM + parm4;
    wire [15:0] cyc_fi_task = ctrl[`LPBC_CTRL_TASK_GATE] ? `LPBC_CYC_TASK_GATE :
                              `LPBC_CYC_TASK_SEG;
    wire [15:0] cyc_fi = !prot ? `LPBC_CYC_FAR_REAL :
                         (kind == lpbc_pkg::LPBC_FAR_CODE) ? `LPBC_CYC_FAR_PM :
                         (kind == lpbc_pkg::LPBC_FAR_GATE_SAME) ? `LPBC_CYC_GATE_SAME :
                         (kind == lpbc_pkg::LPBC_FAR_GATE_MORE) ? cyc_fi_more :
                         cyc_fi_task;
    // Doubleword operand far call
    wire [15:0] cyc_fm_more = (wc == 5'h00) ? `LPBC_CYC_IGATE_MORE :
                              `LPBC_CYC_IGATE_PARM + parm4;
    wire [15:0] cyc_fm_task = ctrl[`LPBC_CTRL_TASK_GATE] ? `LPBC_CYC_ITASK_GATE :
                              `LPBC_CYC_ITASK_SEG;
    wire [15:0] cyc_fm = !prot ? `LPBC_CYC_IFAR_REAL :
                         (kind == lpbc_pkg::LPBC_FAR_CODE) ? `LPBC_CYC_IFAR_PM :
                         (kind == lpbc_pkg::LPBC_FAR_GATE_SAME) ? `LPBC_CYC_IGATE_SAME :
                         (kind == lpbc_pkg::LPBC_FAR_GATE_MORE) ? cyc_fm_more :
                         cyc_fm_task;
    wire [15:0] cyc_call = (call_far ? cyc_fi : call_fmem ? cyc_fm : cyc_near) +
                           next_len;
    wire [15:0] cyc_sel = f_ud ? `LPBC_CYC_FAULT :
                          and_any ? cyc_and :
                          adj ? cyc_adj :
                          bound ? `LPBC_CYC_BOUND : cyc_call;
    wire gate_more = prot && (call_far || call_fmem) &&
                     (kind == lpbc_pkg::LPBC_FAR_GATE_MORE);

    // ----------------------------------------------------------------
    // Cycle timer
    // ----------------------------------------------------------------
    logic start; // Go delayed one edge, so the count sees the new mode bits
    logic tmr_done;
    lpbc_cycle_timer #(
        .CYC_W(CYC_W)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .load(start),
        .count(cyc_sel[CYC_W-1:0]),
        .busy(),
        .done(tmr_done)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Results are published when the timer runs out, so software sees them
    // only after the documented cost has elapsed
    lpbc_pkg::lpbc_state_e next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            lpbc_pkg::LPBC_IDLE: begin
                if (go) begin
                    next_state = lpbc_pkg::LPBC_RUN;
                end
            end
            lpbc_pkg::LPBC_RUN: begin
                if (tmr_done) begin
                    next_state = lpbc_pkg::LPBC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= lpbc_pkg::LPBC_IDLE;
            start <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            start <= go;
        end
    end

    // Commit the outcome of the instruction
    wire commit = (state == lpbc_pkg::LPBC_RUN) && tmr_done;
    wire [15:0] res_lo = and_any ? and_res : adj ? adj_res : is_call ? call_target : opa;
    wire [15:0] res_hi = is_call ? opa : 16'h0000;
    // Overflow and carry cleared, aux carry left as it was
    wire [5:0] and_flags = {1'b0, and_sign, and_zero, flags[2], and_par, 1'b0};
    wire [5:0] adj_flags = {flags[5:4], adj_raise, flags[2:0]};
    wire [5:0] next_flags = f_any ? flags : and_any ? and_flags : adj ? adj_flags : flags;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result <= 32'h0000_0000;
            flags <= `LPBC_FLAGS_RST;
            fault_vec <= 8'h00;
            fault_hit <= 1'b0;
            parm_cnt <= 5'h00;
            cycles <= 16'h0000;
        end else if (ce && commit) begin
            // A faulting instruction leaves its destination untouched
            if (!f_any) begin
                result <= {res_hi, res_lo};
            end
            flags <= next_flags;
            fault_vec <= vec_sel;
            fault_hit <= f_any;
            parm_cnt <= (gate_more && !f_any) ? wc : 5'h00;
            cycles <= cyc_sel;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    wire [31:0] wd = avs_writedata;
    wire [3:0] be = avs_byteenable;
    wire [31:0] ctrl_w = lpbc_merge({16'h0000, ctrl}, wd, be);
    wire [31:0] insn_w = lpbc_merge({16'h0000, insn}, wd, be);
    wire [31:0] opa_w = lpbc_merge({16'h0000, opa}, wd, be);
    wire [31:0] opb_w = lpbc_merge({16'h0000, opb}, wd, be);
    wire [31:0] bnd_w = lpbc_merge(bnd, wd, be);
    wire [31:0] mofs_w = lpbc_merge({11'h000, mofs}, wd, be);
    wire [31:0] mask_w = lpbc_merge({30'h0, irq_mask}, wd, be);
    wire [1:0] stat_clr = (wr_fire && hit_stat && be[0]) ? wd[1:0] : 2'b00;
    wire [1:0] stat_set = {commit && f_any, commit};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `LPBC_CTRL_RST;
            insn <= 16'h0000;
            opa <= 16'h0000;
            opb <= 16'h0000;
            bnd <= 32'h0000_0000;
            mofs <= 21'h00_0000;
        end else if (ce && wr_ops) begin
            // The go bit is a strobe and is never stored
            if (hit_ctrl) ctrl <= {ctrl_w[15:1], 1'b0};
            if (hit_insn) insn <= insn_w[15:0];
            if (hit_opa) opa <= opa_w[15:0];
            if (hit_opb) opb <= opb_w[15:0];
            if (hit_bnd) bnd <= bnd_w;
            if (hit_mofs) mofs <= mofs_w[20:0];
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat <= 2'b00;
            irq_mask <= `LPBC_MASK_RST;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat <= (irq_stat & ~stat_clr) | (ce ? stat_set : 2'b00);
            if (wr_fire && hit_mask) irq_mask <= mask_w[1:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [31:0] status_w = {9'h000, parm_cnt, fault_hit, fault_vec, 2'b00, flags, !idle};
    wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl} :
                         hit_insn ? {16'h0000, insn} :
                         hit_opa ? {16'h0000, opa} :
                         hit_opb ? {16'h0000, opb} :
                         hit_bnd ? bnd :
                         hit_mofs ? {11'h000, mofs} :
                         (avs_address == `LPBC_OFS_RESULT) ? result :
                         (avs_address == `LPBC_OFS_STATUS) ? status_w :
                         (avs_address == `LPBC_OFS_CYCLES) ? {16'h0000, cycles} :
                         hit_stat ? {30'h0, irq_stat} :
                         hit_mask ? {30'h0, irq_mask} : 32'h0000_0000;

    // Waitrequest drops for exactly one cycle per access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            avs_waitrequest <= !(bus_req && avs_waitrequest) || bus_fire;
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

endmodule : lpbc_exec

// ---- dv/lpbc_exec_chk.sv ----
// Checker of bus handshake and reset state at the executer's ports
`timescale 1ns/1ps
module lpbc_exec_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A request not yet answered, with the clock running
    sequence s_req;
        ce && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    ack_next_a: assert property (s_req |=> !avs_waitrequest) else $error("ack late");
    ack_once_a: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("ack held");
    wait_idle_a: assert property (ce && !avs_read && !avs_write |=> avs_waitrequest)
        else $error("ack without request");
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst && ce
        |=> avs_waitrequest && !irq && avs_readdata == 32'h0) else $error("reset state");
    data_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    ce_freeze_a: assert property (!ce |=> $stable(avs_waitrequest) && $stable(avs_readdata)
        && $stable(irq)) else $error("outputs moved with clock enable low");
endmodule : lpbc_exec_chk
bind lpbc_exec lpbc_exec_chk i_lpbc_exec_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

// ---- dv/lpbc_exec_tb.sv ----
// Register-level bench of the executer
`timescale 1ns/1ps
`include "lpbc_params.svh"
module lpbc_exec_tb;
    logic clk, sys_rst, ce, avs_read, avs_write, avs_waitrequest, irq;
    logic [5:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, r_res, r_st, r_cyc, v;
    int n_mismatch, compares, cyc_cnt;
    lpbc_exec i_lpbc_exec (.clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    task stop_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    // Request held until the edge where waitrequest is seen low
    task acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : acc
    // Load operands, start, wait for done, fetch results, clear the event
    task ex(input logic [11:0] c, input logic [15:0] i, a, b, input logic [31:0] d, m);
        chk({31'h0, irq}, 32'h0);
        acc(1, `LPBC_OFS_INSN, {16'h0, i});
        acc(1, `LPBC_OFS_OPA, {16'h0, a});
        acc(1, `LPBC_OFS_OPB, {16'h0, b});
        acc(1, `LPBC_OFS_BND, d);
        acc(1, `LPBC_OFS_MOFS, m);
        acc(1, `LPBC_OFS_CTRL, {20'h0, c});
        // Clock enable low for two edges with the instruction in flight
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        do acc(0, `LPBC_OFS_IRQ_STAT, 32'h0); while (v[0] !== 1'b1);
        chk({31'h0, irq}, 32'h1);
        acc(0, `LPBC_OFS_RESULT, 32'h0); r_res = v;
        acc(0, `LPBC_OFS_STATUS, 32'h0); r_st = v;
        acc(0, `LPBC_OFS_CYCLES, 32'h0); r_cyc = v;
        acc(1, `LPBC_OFS_IRQ_STAT, 32'h3);
        repeat (3) @(posedge clk);
        $display("test %h done at %0t", i, $time);
    endtask : ex
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Hang guard far above the expected run length
    always @(posedge clk) if (++cyc_cnt == 20000) begin n_mismatch++; stop_test; end
    initial begin
        {sys_rst, ce, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} =
            {2'b11, 40'h0, 4'hf};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        acc(1, `LPBC_OFS_IRQ_MASK, 32'h1);
        acc(0, 6'h3c, 32'h0); chk(v, 32'h0);
        ex(12'h001, 16'hc021, 16'h0f0f, 16'h00ff, 0, 0); chk(r_res & 'hffff, 'h000f);
        chk(r_st[6:0], 7'h04); chk(r_cyc, 2);
        ex(12'h001, 16'h0025, 16'h8000, 16'h8001, 0, 0); chk(r_st[6:0], 7'h24);
        chk(r_cyc, 3);
        ex(12'h007, 16'h0021, 16'h00f0, 16'h0f00, 0, 0); chk(r_st[6:0], 7'h14);
        chk(r_cyc, 7);
        ex(12'h003, 16'h0021, 1, 1, 0, 0); chk(r_st[17:9], 9'h10d);
        ex(12'h01f, 16'h0021, 1, 1, 0, 0); chk(r_st[17:9], 9'h10c);
        ex(12'h00f, 16'h0021, 1, 1, 0, 0); chk(r_st[17:9], 9'h10d);
        ex(12'h003, 16'hc063, 16'h1230, 3, 0, 0); chk(r_res & 'hffff, 'h1233);
        chk(r_st[4], 1); chk(r_cyc, 10);
        ex(12'h003, 16'hc063, 16'h1233, 1, 0, 0); chk(r_res & 'hffff, 'h1233);
        chk(r_st[4], 0);
        ex(12'h001, 16'hc063, 0, 3, 0, 0); chk(r_st[17:9], 9'h106);
        ex(12'h003, 16'h0062, 16'hffff, 0, 'h0005fffe, 0); chk(r_st[17], 0);
        ex(12'h003, 16'h0062, 6, 0, 'h0005fffe, 0); chk(r_st[17:9], 9'h105);
        ex(12'h001, 16'hc062, 0, 0, 0, 0); chk(r_st[17:9], 9'h106);
        ex(12'h001, 16'h0062, 0, 0, 0, 'hfffd); chk(r_st[17:9], 9'h10d);
        ex(12'h201, 16'h00e8, 16'h1000, 16'hfff0, 0, 0); chk(r_res, 'h10000ff0);
        chk(r_cyc, 9);
        ex(12'h043, 16'h009a, 0, 0, 0, 'h30000); chk(r_cyc, 98);
        chk(r_st[22:18], 3);
        ex(12'h001, 16'h18ff, 0, 0, 0, 0); chk(r_cyc, 16);
        // Only the low lane may land in the first operand register
        avs_byteenable <= 4'h1;
        acc(1, `LPBC_OFS_OPA, 32'h0000_abcd);
        avs_byteenable <= 4'hf;
        acc(0, `LPBC_OFS_OPA, 32'h0);
        chk(v, 32'h0000_00cd);
        $display("byte lane test done at %0t", $time);
        stop_test;
    end
endmodule : lpbc_exec_tb
